/* File: logic/rwwt_pkg.sv */
// package for the runaway watchdog / warm-up timer
// assumes a 32-bit avalon-mm slave bus and a single 40 MHz clock domain
// Functional notes
// - 7-stage prescaler feeds 15-stage main counter
// - two-bit field picks overflow tap 2^15..2^21
// - detect period resets to 00, shortest
// - overflow raises non-maskable interrupt request
// - enable bit resets to one
// - disable needs enable cleared then B1 code
// - writing enable one re-enables directly
// - clear code 4E zeroes the counters
// - command register write-only, other codes ignored
// - reset-connect bit routes overflow to reset
// - warm-up select picks 2^7 or 2^9 tap
// - quick warm-up forces the 2^7 end point
// - quick warm-up forced off while watchdog runs
// - counters time warm-up on stop exit
// - counting halts in deep idle and stop
// - counting restarts right after reset release
package rwwt_pkg;
    // word addresses on the bus
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_CMD = 4'h1;
    localparam logic [3:0] ADDR_QUICK = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
    localparam logic [3:0] ADDR_WARM = 4'h6;
    localparam logic [7:0] CMD_OFFSET = 8'h5d;
    // watchdog_mode field positions
    localparam int MODE_ENABLE_POS = 7;
    localparam int MODE_PERIOD_LSB = 5;
    localparam int MODE_WARM_POS = 4;
    localparam int MODE_RESCON_POS = 1;
    localparam logic [7:0] MODE_RESET = 8'h80;
    // command codes
    localparam logic [7:0] CODE_DISABLE = 8'hb1;
    localparam logic [7:0] CODE_CLEAR = 8'h4e;
    // counter geometry
    localparam int PRE_STAGES = 7;
    localparam int MAIN_STAGES = 15;
    localparam int WARM_SHORT_TAP = 7;
    localparam int WARM_LONG_TAP = 9;
    // interrupt status bits
    localparam int IRQ_OVF = 0;
    localparam int IRQ_WARM = 1;
    localparam int IRQ_BITS = 2;
    localparam int RST_PULSE_CYCLES = 4;
endpackage

/* File: logic/rwwt_cnt_if.sv */
// carrier between the watchdog top and its counter chain
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface rwwt_cnt_if;
    logic run;
    logic clear;
    logic [21:0] count;
    modport ctrl (output run, output clear, input count);
    modport chain (input run, input clear, output count);
endinterface

/* File: logic/rwwt_counter.sv */
// prescaler plus main binary counter chain
// assumes run and clear are synchronous to clk; the caller drives them combinationally
`timescale 1ns/1ps
module rwwt_counter #(
    parameter int PRE = rwwt_pkg::PRE_STAGES,
    parameter int MAIN = rwwt_pkg::MAIN_STAGES
) (
    input wire logic clk,
    input wire logic resetn,
    rwwt_cnt_if.chain cnt
);
    initial begin
        if (PRE + MAIN != 22) begin
            $error("counter chain must total 22 stages");
        end
    end

    logic [PRE+MAIN-1:0] value;

    // one ripple-free chain; prescaler is the low stages
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            value <= '0;
        end else if (cnt.clear) begin
            value <= '0;
        end else if (cnt.run) begin
            value <= value + 1'b1;
        end
    end

    assign cnt.count = value;
endmodule

/* File: logic/rwwt_top.sv */
// runaway watchdog and oscillator warm-up timer with avalon-mm slave
// assumes inputs synchronous to clk; reset_request feeds the chip reset
`timescale 1ns/1ps
module rwwt_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic deep_idle,
    input wire logic stop_mode,
    input wire logic warmup_start,
    output logic warmup_done,
    output logic runaway_nmi,
    output logic watchdog_out,
    output logic reset_request,
    output logic irq
);
    rwwt_cnt_if cnt ();

    rwwt_counter u_counter (
        .clk(clk),
        .resetn(resetn),
        .cnt(cnt)
    );

    typedef enum logic [1:0] {ST_IDLE, ST_ANSWER} rwwt_bus_e;
    typedef enum logic [1:0] {WD_ON, WD_OFF, WD_WARM} rwwt_mode_e;

    rwwt_bus_e bus_state;
    rwwt_mode_e wd_state;
    logic [7:0] watchdog_mode;
    logic quick_warm;
    logic [rwwt_pkg::IRQ_BITS-1:0] irq_status;
    logic [rwwt_pkg::IRQ_BITS-1:0] irq_enable;
    logic tap_prev;
    logic warm_prev;
    logic [2:0] rst_count;
    logic wr_mode, wr_cmd, wr_quick, wr_en, wr_clr;
    logic clear_req, next_tap, ovf_pulse, warm_tap, warm_pulse;
    logic [7:0] wdata;
    logic [1:0] period_sel;

    // tap index for a detect period code; 2^15 plus two per step
    function automatic int tap_of(input logic [1:0] sel);
        return 14 + 2 * int'(sel);
    endfunction

    assign wdata = avs_writedata[7:0];
    assign period_sel = watchdog_mode[rwwt_pkg::MODE_PERIOD_LSB+:2];

    // a write lands once, at the edge where waitrequest is seen low
    assign wr_mode = avs_write && bus_state == ST_ANSWER && avs_byteenable[0]
        && avs_address == rwwt_pkg::ADDR_MODE;
    assign wr_cmd = avs_write && bus_state == ST_ANSWER && avs_byteenable[0]
        && avs_address == rwwt_pkg::ADDR_CMD;
    assign wr_quick = avs_write && bus_state == ST_ANSWER
        && avs_byteenable[0] && avs_address == rwwt_pkg::ADDR_QUICK;
    assign wr_en = avs_write && bus_state == ST_ANSWER && avs_byteenable[0]
        && avs_address == rwwt_pkg::ADDR_IRQ_EN;
    assign wr_clr = avs_write && bus_state == ST_ANSWER && avs_byteenable[0]
        && avs_address == rwwt_pkg::ADDR_IRQ_CLR;

    // counters run unless halted by low-power modes
    assign cnt.run = !deep_idle && !stop_mode;
    assign clear_req = wr_cmd && wdata == rwwt_pkg::CODE_CLEAR;
    assign cnt.clear = clear_req || (warmup_start && wd_state != WD_WARM);

    // overflow of the selected tap is its falling edge
    assign next_tap = cnt.count[tap_of(period_sel)];
    assign ovf_pulse = tap_prev && !next_tap && wd_state == WD_ON;

    // warm-up end point: quick bit wins over the select bit
    assign warm_tap = quick_warm ? cnt.count[rwwt_pkg::WARM_SHORT_TAP]
        : (watchdog_mode[rwwt_pkg::MODE_WARM_POS]
           ? cnt.count[rwwt_pkg::WARM_LONG_TAP]
           : cnt.count[rwwt_pkg::WARM_SHORT_TAP]);
    assign warm_pulse = wd_state == WD_WARM && warm_tap && !warm_prev;

    // bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_state <= ST_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (bus_state == ST_IDLE && (avs_read || avs_write)) begin
            bus_state <= ST_ANSWER;
            avs_waitrequest <= 1'b0;
        end else begin
            bus_state <= ST_IDLE;
            avs_waitrequest <= 1'b1;
        end
    end

    // read mux; unmapped and write-only addresses read zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= '0;
        end else if (bus_state == ST_IDLE && avs_read) begin
            unique case (avs_address)
                rwwt_pkg::ADDR_MODE: avs_readdata <= {24'h0, watchdog_mode};
                rwwt_pkg::ADDR_QUICK: avs_readdata <= {31'h0, quick_warm};
                rwwt_pkg::ADDR_STATUS: avs_readdata <= {30'h0, irq_status};
                rwwt_pkg::ADDR_IRQ_EN: avs_readdata <= {30'h0, irq_enable};
                rwwt_pkg::ADDR_WARM: avs_readdata <= {31'h0, warmup_done};
                default: avs_readdata <= '0;
            endcase
        end
    end

    // mode register; enable bit and period reset to documented values
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            watchdog_mode <= rwwt_pkg::MODE_RESET;
        end else if (wr_mode) begin
            watchdog_mode <= wdata;
        end
    end

    // watchdog state: disabling needs both steps in order
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wd_state <= WD_ON;
        end else begin
            unique case (wd_state)
                WD_ON: begin
                    if (wr_cmd && wdata == rwwt_pkg::CODE_DISABLE
                        && !watchdog_mode[rwwt_pkg::MODE_ENABLE_POS]) begin
                        wd_state <= WD_OFF;
                    end else if (warmup_start) begin
                        wd_state <= WD_WARM;
                    end
                end
                WD_OFF: begin
                    if (wr_mode && wdata[rwwt_pkg::MODE_ENABLE_POS]) begin
                        wd_state <= WD_ON;
                    end else if (warmup_start) begin
                        wd_state <= WD_WARM;
                    end
                end
                WD_WARM: begin
                    // return to the mode the enable bit asks for
                    if (warm_pulse) begin
                        wd_state <= watchdog_mode[rwwt_pkg::MODE_ENABLE_POS]
                            ? WD_ON : WD_OFF;
                    end
                end
                default: wd_state <= WD_ON;
            endcase
        end
    end

    // quick warm-up bit, held clear while the watchdog runs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quick_warm <= 1'b0;
        end else if (wd_state == WD_ON) begin
            quick_warm <= 1'b0;
        end else if (wr_quick) begin
            quick_warm <= wdata[0];
        end
    end

    // edge history of the taps
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tap_prev <= 1'b0;
            warm_prev <= 1'b0;
        end else begin
            tap_prev <= next_tap;
            warm_prev <= warm_tap;
        end
    end

    // runaway outputs: nmi and pin pulse one cycle per overflow
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            runaway_nmi <= 1'b0;
            watchdog_out <= 1'b0;
            warmup_done <= 1'b0;
        end else begin
            runaway_nmi <= ovf_pulse;
            watchdog_out <= ovf_pulse;
            warmup_done <= warm_pulse;
        end
    end

    // reset request stretched so the chip reset is seen cleanly;
    // it resets this block too through the chip reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_count <= '0;
            reset_request <= 1'b0;
        end else if (ovf_pulse
                     && watchdog_mode[rwwt_pkg::MODE_RESCON_POS]) begin
            rst_count <= 3'(rwwt_pkg::RST_PULSE_CYCLES);
            reset_request <= 1'b1;
        end else if (rst_count != '0) begin
            rst_count <= rst_count - 3'd1;
            reset_request <= rst_count != 3'd1;
        end else begin
            reset_request <= 1'b0;
        end
    end

    // sticky status: a set in the clear cycle wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status
                & ~(wr_clr ? wdata[rwwt_pkg::IRQ_BITS-1:0] : '0))
                | {warm_pulse, ovf_pulse};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_enable <= '0;
        end else if (wr_en) begin
            irq_enable <= wdata[rwwt_pkg::IRQ_BITS-1:0];
        end
    end

    // level interrupt registered from masked status
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end
endmodule

/* File: dv/rwwt_monitor.sv */
// checker on the watchdog top ports
// assumes one clock domain and the one-cycle bus answer
`timescale 1ns/1ps
module rwwt_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic deep_idle,
    input wire logic stop_mode,
    input wire logic warmup_done,
    input wire logic runaway_nmi,
    input wire logic watchdog_out,
    input wire logic reset_request
);
    logic req;
    // a request in either direction
    assign req = avs_read | avs_write;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_pin_pair: assert property (runaway_nmi == watchdog_out)
        else $error("watchdog pin differs from nmi");
    a_nmi_pulse: assert property (runaway_nmi |=> !runaway_nmi)
        else $error("nmi longer than one cycle");
    a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not one cycle later");
    a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_cmd_reads: assert property (avs_read && avs_address == 4'h1 &&
        avs_waitrequest |=> avs_readdata == 32'h0)
        else $error("command register readable");
    a_rst_len: assert property ($rose(reset_request) |->
        reset_request [*4] ##1 !reset_request)
        else $error("reset request length wrong");
    a_rst_cause: assert property ($rose(reset_request) |->
        runaway_nmi || $past(runaway_nmi) || $past(runaway_nmi, 2))
        else $error("reset request without overflow");
    a_warm_pulse: assert property (warmup_done |=> !warmup_done)
        else $error("warm-up end longer than one cycle");
    a_halt_quiet: assert property ((deep_idle || stop_mode) [*3] |->
        !runaway_nmi && !warmup_done)
        else $error("event while counters halted");
    c_nmi: cover property (runaway_nmi);
    c_warm: cover property (warmup_done);
    c_rst: cover property ($rose(reset_request));
endmodule
bind rwwt_top rwwt_monitor u_mon (.clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .deep_idle, .stop_mode,
    .warmup_done, .runaway_nmi, .watchdog_out, .reset_request);

/* File: dv/runaway_watchdog_warmup_timer_tb_top.sv */
// self-checking bench for the runaway watchdog and warm-up timer
// assumes rwwt_top with a one-cycle avalon answer and the bound monitor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module runaway_watchdog_warmup_timer_tb_top;
    logic clk = 1'b0;
    logic resetn, avs_read, avs_write, avs_waitrequest, irq;
    logic deep_idle, stop_mode, warmup_start, warmup_done;
    logic runaway_nmi, watchdog_out, reset_request;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rq;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int n_nmi = 0;
    int m_mode;
    int unsigned seed = 93530;
    rwwt_top uut (.clk, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .deep_idle, .stop_mode, .warmup_start,
        .warmup_done, .runaway_nmi, .watchdog_out, .reset_request, .irq);
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // cycle count and nmi tally used as the model's time base
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (runaway_nmi === 1'b1)
            n_nmi <= n_nmi + 1;
    end
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // a few cycles of slack: the exact pipeline offset is the design's own
    function automatic logic near(input int n, input int e);
        return (n >= e - 3) && (n <= e + 3);
    endfunction
    task automatic conclude();
        if (n_mismatch == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one avalon access; holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input int d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= 32'(d);
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rq = avs_readdata;
        if (k >= 50)
            n_mismatch++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_on(input logic s, input int lim);
        int k;
        k = 0;
        while ((s ? warmup_done : runaway_nmi) !== 1'b1 && k < lim) begin
            @(posedge clk);
            k++;
        end
        if (k >= lim)
            n_mismatch++;
    endtask
    // warm-up run, optionally halted by s for h cycles on the way
    task automatic warm(input int e, input int h, input logic [1:0] s);
        int t;
        warmup_start <= 1'b1;
        @(posedge clk);
        warmup_start <= 1'b0;
        t = cyc;
        if (h > 0) begin
            repeat (40) @(posedge clk);
            {stop_mode, deep_idle} <= s;
            repeat (h) @(posedge clk);
            {stop_mode, deep_idle} <= 2'b00;
        end
        wait_on(1, 2000);
        `CHK("warm_cycles", 1'b1, near(cyc - t, e + h))
    endtask
    // main sequence
    initial begin
        logic [7:0] c;
        int t;
        int h;
        resetn = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        deep_idle = 1'b0;
        stop_mode = 1'b0;
        warmup_start = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        m_mode = 128;
        @(posedge clk);
        bus(0, 4'h0, 0);
        `CHK("mode", m_mode[7:0], rq[7:0] & 8'hf2)
        bus(0, 4'h1, 0);
        `CHK("cmd", 8'h00, rq[7:0])
        bus(0, 4'hf, 0);
        `CHK("unmapped", 32'h0, rq)
        bus(1, 4'h4, 1);
        m_mode = 130;
        bus(1, 4'h0, m_mode);
        repeat (20000) @(posedge clk);
        `CHK("early_nmi", 0, n_nmi)
        bus(1, 4'h1, 8'h4e);
        t = cyc;
        bus(1, 4'h1, 8'hb1);
        repeat (4) begin
            c = 8'(rnd());
            if (c == 8'hb1 || c == 8'h4e)
                c = 8'h00;
            bus(1, 4'h1, c);
        end
        // period 00: overflow 2^15 cycles after the clear
        wait_on(0, 40000);
        `CHK("ovf_time", 1'b1, near(cyc - t, 32768))
        `CHK("pin", 1'b1, watchdog_out)
        repeat (2) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        `CHK("rst_req", 1'b1, reset_request)
        bus(0, 4'h3, 0);
        `CHK("status", 1'b1, rq[0])
        bus(1, 4'h5, 1);
        @(posedge clk);
        `CHK("irq_clr", 1'b0, irq)
        // stand in for the chip reset that reset_request drives
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        m_mode = 128;
        @(posedge clk);
        bus(0, 4'h0, 0);
        `CHK("mode_rst", m_mode[7:0], rq[7:0] & 8'hf2)
        m_mode = 0;
        bus(1, 4'h0, m_mode);
        bus(1, 4'h1, 8'hb1);
        t = n_nmi;
        repeat (33000) @(posedge clk);
        `CHK("off_nmi", t, n_nmi)
        bus(1, 4'h2, 1);
        bus(0, 4'h2, 0);
        `CHK("quick_off", 1'b1, rq[0])
        m_mode = 16;
        bus(1, 4'h0, m_mode);
        warm(128, 0, 2'b00);
        bus(1, 4'h2, 0);
        h = 50 + int'(rnd() % 200);
        warm(512, h, 2'b01);
        m_mode = 128;
        bus(1, 4'h0, m_mode);
        bus(1, 4'h2, 1);
        bus(0, 4'h2, 0);
        `CHK("quick_on", 1'b0, rq[0])
        warm(128, h, 2'b10);
        conclude();
    end
    // the sequence needs about 87k cycles; stop a hang at 100k
    initial begin
        #2500000;
        n_mismatch++;
        conclude();
    end
endmodule
